/* File: verilog/srpc_pkg.sv */
`default_nettype none
package srpc_pkg;
	// Processor port geometry
	localparam int SRPC_ADDR_W = 10;
	localparam int SRPC_DATA_W = 8;
	localparam int SRPC_PKT_LEN_W = 16;

	// Register byte addresses
	localparam logic [9:0] SRPC_SIZE_VIOL_B0 = 10'h114;
	localparam logic [9:0] SRPC_SIZE_VIOL_B1 = 10'h115;
	localparam logic [9:0] SRPC_SIZE_VIOL_B2 = 10'h116;
	localparam logic [9:0] SRPC_GOOD_B0 = 10'h118;
	localparam logic [9:0] SRPC_GOOD_B1 = 10'h119;
	localparam logic [9:0] SRPC_GOOD_B2 = 10'h11A;
	localparam logic [9:0] SRPC_GOOD_B3 = 10'h11B;
	localparam logic [9:0] SRPC_ABORT_B0 = 10'h11C;
	localparam logic [9:0] SRPC_ABORT_B1 = 10'h11D;
	localparam logic [9:0] SRPC_ABORT_B2 = 10'h11E;
	localparam logic [9:0] SRPC_ABORT_B3 = 10'h11F;
	localparam logic [9:0] SRPC_UPDATE_REQ = 10'h120;
	localparam logic [9:0] SRPC_UPDATE_DONE = 10'h121;
	localparam logic [9:0] SRPC_X86_STATUS = 10'h122;
	localparam logic [9:0] SRPC_X86_IRQ_EN = 10'h123;

	// Field positions
	localparam int SRPC_UPDATE_BIT = 0;
	localparam int SRPC_ADDR_MISMATCH_BIT = 0;
	localparam int SRPC_CONTROL_MISMATCH_BIT = 1;
	localparam int SRPC_SAPI_LOW_MISMATCH_BIT = 2;
	localparam int SRPC_SAPI_HIGH_MISMATCH_BIT = 3;

	// Reset values
	localparam logic [7:0] SRPC_REG_RESET = 8'h00;
	localparam logic [3:0] SRPC_FLAGS_RESET = 4'h0;
	localparam logic [7:0] SRPC_UNMAPPED_READ = 8'h00;

	// Processor port pins after synchronisation
	typedef struct packed {
		logic cs_n;
		logic rd_n;
		logic wr_n;
		logic [SRPC_ADDR_W-1:0] addr;
		logic [SRPC_DATA_W-1:0] wdata;
	} srpc_cpu_t;

	// End-of-packet report from the receive packet processor
	typedef struct packed {
		logic valid;
		logic abort;
		logic size_violation;
		logic [SRPC_PKT_LEN_W-1:0] bytes;
	} srpc_pkt_t;

	// Received X.86 header fields
	typedef struct packed {
		logic valid;
		logic [7:0] sapi_high;
		logic [7:0] sapi_low;
		logic [7:0] control;
		logic [7:0] address;
	} srpc_hdr_t;
endpackage
`default_nettype wire

/* File: verilog/srpc_rx_perf_counters.sv */
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - A 24-bit running count of received packets with a size violation is kept.
// - Bytes of size-violation packets go to the aborted byte count, not the good one.
// - A 32-bit count of bytes in packets stored without an abort indication is kept.
// - A separate 32-bit count of bytes in packets stored with an abort indication is kept.
// - Byte counts take whatever length the packet processor reports, dropped bytes included.
// - Each wide count reads as consecutive bytes, low byte first, from 114h, 118h and 11Ch.
// - A low-to-high write of the update bit snapshots the counts and restarts the counters.
// - The update acts on these serial receive counters and on nothing else.
// - The done flag sets when the snapshot ends and clears when the update bit returns to 0.
// - Bit 3 latches a SAPI high octet mismatch and clears on read.
// - Bit 2 latches a SAPI low octet mismatch and clears on read.
// - Bit 1 latches a control field mismatch and clears on read.
// - Bit 0 latches an address field mismatch and clears on read.
// - Each mismatch flag raises the interrupt only while its enable bit is 1.
module srpc_rx_perf_counters
	import srpc_pkg::*;
#(
	parameter int SIZE_VIOL_W = 24,
	parameter int BYTE_CNT_W = 32
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic cpu_cs_n,
	input wire logic cpu_rd_n,
	input wire logic cpu_wr_n,
	input wire logic [SRPC_ADDR_W-1:0] cpu_addr,
	input wire logic [SRPC_DATA_W-1:0] cpu_data_in,
	output logic [SRPC_DATA_W-1:0] cpu_data_out,
	output logic cpu_data_oe,
	input wire srpc_pkt_t rx_pkt,
	input wire srpc_hdr_t rx_hdr,
	input wire logic [7:0] expected_sapi_high,
	input wire logic [7:0] expected_sapi_low,
	input wire logic [7:0] expected_control_value,
	input wire logic [7:0] expected_address_value,
	output logic x86_mismatch_irq
);

	// Processor port synchroniser stages
	srpc_cpu_t cpu_meta_reg;
	srpc_cpu_t cpu_sync_reg;
	logic rd_active_reg;
	logic wr_active_reg;

	// Running counters
	logic [SIZE_VIOL_W-1:0] size_viol_run_reg;
	logic [BYTE_CNT_W-1:0] good_run_reg;
	logic [BYTE_CNT_W-1:0] abort_run_reg;

	// Snapshot registers seen by software
	logic [SIZE_VIOL_W-1:0] size_viol_snap_reg;
	logic [BYTE_CNT_W-1:0] good_snap_reg;
	logic [BYTE_CNT_W-1:0] abort_snap_reg;

	// Control and status
	logic update_req_reg;
	logic snap_pending_reg;
	logic update_done_reg;
	logic [3:0] mismatch_flags_reg;
	logic [3:0] irq_enable_reg;

	// Output flops
	logic [SRPC_DATA_W-1:0] rdata_reg;
	logic rdata_oe_reg;
	logic irq_reg;

	// Bus decode
	wire logic rd_active;
	wire logic wr_active;
	wire logic rd_start;
	wire logic wr_start;
	wire logic [SRPC_ADDR_W-1:0] bus_addr;
	wire logic [SRPC_DATA_W-1:0] bus_wdata;
	wire logic wr_update;
	wire logic wr_irq_en;
	wire logic rd_status;
	wire logic update_rise;
	wire logic update_fall;
	logic [SRPC_DATA_W-1:0] read_mux;

	// Packet accounting
	wire logic pkt_is_bad;
	wire logic [BYTE_CNT_W-1:0] pkt_bytes_ext;
	wire logic [BYTE_CNT_W-1:0] good_add;
	wire logic [BYTE_CNT_W-1:0] abort_add;
	wire logic [SIZE_VIOL_W-1:0] size_viol_add;
	wire logic [SIZE_VIOL_W-1:0] size_viol_sum;
	wire logic [BYTE_CNT_W-1:0] good_sum;
	wire logic [BYTE_CNT_W-1:0] abort_sum;

	// Header comparison
	wire logic [3:0] mismatch_set;
	wire logic [3:0] mismatch_clear;
	wire logic [3:0] mismatch_next;
	wire logic [3:0] irq_source;
	wire logic [7:0] hdr_seen [4];
	wire logic [7:0] hdr_expected [4];

	// Snapshot byte lanes
	localparam int SIZE_VIOL_BYTES = SIZE_VIOL_W / 8;
	localparam int BYTE_CNT_BYTES = BYTE_CNT_W / 8;
	wire logic [7:0] size_viol_lane [SIZE_VIOL_BYTES];
	wire logic [7:0] good_lane [BYTE_CNT_BYTES];
	wire logic [7:0] abort_lane [BYTE_CNT_BYTES];

	// Two flops on every processor pin before use
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cpu_meta_reg <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0};
			cpu_sync_reg <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0};
		end else begin
			cpu_meta_reg <= '{cs_n: cpu_cs_n, rd_n: cpu_rd_n, wr_n: cpu_wr_n,
				addr: cpu_addr, wdata: cpu_data_in};
			cpu_sync_reg <= cpu_meta_reg;
		end
	end

	// Strobe edge history
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rd_active_reg <= 1'b0;
			wr_active_reg <= 1'b0;
		end else begin
			rd_active_reg <= rd_active;
			wr_active_reg <= wr_active;
		end
	end

	// Access detection, one action per strobe
	assign rd_active = !cpu_sync_reg.cs_n && !cpu_sync_reg.rd_n;
	assign wr_active = !cpu_sync_reg.cs_n && !cpu_sync_reg.wr_n;
	assign rd_start = rd_active && !rd_active_reg;
	assign wr_start = wr_active && !wr_active_reg;
	assign bus_addr = cpu_sync_reg.addr;
	assign bus_wdata = cpu_sync_reg.wdata;
	assign wr_update = wr_start && (bus_addr == SRPC_UPDATE_REQ);
	assign wr_irq_en = wr_start && (bus_addr == SRPC_X86_IRQ_EN);
	assign rd_status = rd_start && (bus_addr == SRPC_X86_STATUS);

	// Update bit edges as written by software
	assign update_rise = wr_update && bus_wdata[SRPC_UPDATE_BIT] && !update_req_reg;
	assign update_fall = wr_update && !bus_wdata[SRPC_UPDATE_BIT];

	// Snapshots cut into bytes, lane 0 holding the low byte
	for (genvar b = 0; b < SIZE_VIOL_BYTES; b++) begin : g_size_viol_lane
		assign size_viol_lane[b] = size_viol_snap_reg[8*b +: 8];
	end
	for (genvar b = 0; b < BYTE_CNT_BYTES; b++) begin : g_count_lane
		assign good_lane[b] = good_snap_reg[8*b +: 8];
		assign abort_lane[b] = abort_snap_reg[8*b +: 8];
	end

	// Read multiplexer, low byte at the lowest address
	always_comb begin
		read_mux = SRPC_UNMAPPED_READ;
		case (bus_addr)
			SRPC_SIZE_VIOL_B0: read_mux = size_viol_lane[0];
			SRPC_SIZE_VIOL_B1: read_mux = size_viol_lane[1];
			SRPC_SIZE_VIOL_B2: read_mux = size_viol_lane[2];
			SRPC_GOOD_B0: read_mux = good_lane[0];
			SRPC_GOOD_B1: read_mux = good_lane[1];
			SRPC_GOOD_B2: read_mux = good_lane[2];
			SRPC_GOOD_B3: read_mux = good_lane[3];
			SRPC_ABORT_B0: read_mux = abort_lane[0];
			SRPC_ABORT_B1: read_mux = abort_lane[1];
			SRPC_ABORT_B2: read_mux = abort_lane[2];
			SRPC_ABORT_B3: read_mux = abort_lane[3];
			SRPC_UPDATE_REQ: read_mux = {7'h00, update_req_reg};
			SRPC_UPDATE_DONE: read_mux = {7'h00, update_done_reg};
			SRPC_X86_STATUS: read_mux = {4'h0, mismatch_flags_reg};
			SRPC_X86_IRQ_EN: read_mux = {4'h0, irq_enable_reg};
			default: read_mux = SRPC_UNMAPPED_READ;
		endcase
	end

	// Read data is captured at the start of the strobe and driven while it lasts
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= SRPC_REG_RESET;
			rdata_oe_reg <= 1'b0;
		end else begin
			if (rd_start) begin
				rdata_reg <= read_mux;
			end
			rdata_oe_reg <= rd_active;
		end
	end

	// Per-packet contributions; size violations count as aborted bytes
	assign pkt_is_bad = rx_pkt.abort || rx_pkt.size_violation;
	assign pkt_bytes_ext = BYTE_CNT_W'(rx_pkt.bytes);
	assign good_add = (rx_pkt.valid && !pkt_is_bad) ? pkt_bytes_ext : '0;
	assign abort_add = (rx_pkt.valid && pkt_is_bad) ? pkt_bytes_ext : '0;
	assign size_viol_add = (rx_pkt.valid && rx_pkt.size_violation) ?
		SIZE_VIOL_W'(1) : '0;
	assign size_viol_sum = size_viol_run_reg + size_viol_add;
	assign good_sum = good_run_reg + good_add;
	assign abort_sum = abort_run_reg + abort_add;

	// Size violation counter restarts on update, keeping a packet that ends in that cycle
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			size_viol_run_reg <= '0;
		end else if (update_rise) begin
			size_viol_run_reg <= size_viol_add;
		end else begin
			size_viol_run_reg <= size_viol_sum;
		end
	end

	// Good byte counter, same restart rule
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			good_run_reg <= '0;
		end else if (update_rise) begin
			good_run_reg <= good_add;
		end else begin
			good_run_reg <= good_sum;
		end
	end

	// Aborted byte counter, same restart rule
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			abort_run_reg <= '0;
		end else if (update_rise) begin
			abort_run_reg <= abort_add;
		end else begin
			abort_run_reg <= abort_sum;
		end
	end

	// Size violation snapshot, serial receive counters only
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			size_viol_snap_reg <= '0;
		end else if (update_rise) begin
			size_viol_snap_reg <= size_viol_run_reg;
		end
	end

	// Good byte snapshot
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			good_snap_reg <= '0;
		end else if (update_rise) begin
			good_snap_reg <= good_run_reg;
		end
	end

	// Aborted byte snapshot
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			abort_snap_reg <= '0;
		end else if (update_rise) begin
			abort_snap_reg <= abort_run_reg;
		end
	end

	// Update request bit as held by software
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			update_req_reg <= 1'b0;
		end else if (wr_update) begin
			update_req_reg <= bus_wdata[SRPC_UPDATE_BIT];
		end
	end

	// Done flag follows the snapshot, dropped when the request returns to 0
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			snap_pending_reg <= 1'b0;
			update_done_reg <= 1'b0;
		end else begin
			snap_pending_reg <= update_rise;
			if (update_fall || update_rise) begin
				update_done_reg <= 1'b0;
			end else if (snap_pending_reg) begin
				update_done_reg <= 1'b1;
			end
		end
	end

	// Header fields lined up with their flag positions
	assign hdr_seen[SRPC_SAPI_HIGH_MISMATCH_BIT] = rx_hdr.sapi_high;
	assign hdr_seen[SRPC_SAPI_LOW_MISMATCH_BIT] = rx_hdr.sapi_low;
	assign hdr_seen[SRPC_CONTROL_MISMATCH_BIT] = rx_hdr.control;
	assign hdr_seen[SRPC_ADDR_MISMATCH_BIT] = rx_hdr.address;
	assign hdr_expected[SRPC_SAPI_HIGH_MISMATCH_BIT] = expected_sapi_high;
	assign hdr_expected[SRPC_SAPI_LOW_MISMATCH_BIT] = expected_sapi_low;
	assign hdr_expected[SRPC_CONTROL_MISMATCH_BIT] = expected_control_value;
	assign hdr_expected[SRPC_ADDR_MISMATCH_BIT] = expected_address_value;

	// One comparator and one interrupt gate per flag
	for (genvar f = 0; f < 4; f++) begin : g_flag
		assign mismatch_set[f] = rx_hdr.valid &&
			(hdr_seen[f] != hdr_expected[f]);
		assign irq_source[f] = mismatch_flags_reg[f] && irq_enable_reg[f];
	end

	// Clear only what the read returned; a new set wins
	assign mismatch_clear = rd_status ? mismatch_flags_reg : 4'h0;
	assign mismatch_next = (mismatch_flags_reg & ~mismatch_clear) | mismatch_set;

	// Latched mismatch flags
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			mismatch_flags_reg <= SRPC_FLAGS_RESET;
		end else begin
			mismatch_flags_reg <= mismatch_next;
		end
	end

	// Interrupt enables
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			irq_enable_reg <= SRPC_FLAGS_RESET;
		end else if (wr_irq_en) begin
			irq_enable_reg <= bus_wdata[3:0];
		end
	end

	// Interrupt from enabled flags only
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |irq_source;
		end
	end

	// Outputs straight from flops
	assign cpu_data_out = rdata_reg;
	assign cpu_data_oe = rdata_oe_reg;
	assign x86_mismatch_irq = irq_reg;

endmodule
`default_nettype wire

/* File: tb/srpc_rx_perf_counters_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module srpc_rx_perf_counters_properties
	import srpc_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic cpu_cs_n,
	input wire logic cpu_rd_n,
	input wire logic cpu_wr_n,
	input wire logic [SRPC_ADDR_W-1:0] cpu_addr,
	input wire logic [SRPC_DATA_W-1:0] cpu_data_out,
	input wire logic cpu_data_oe,
	input wire srpc_hdr_t rx_hdr,
	input wire logic x86_mismatch_irq
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// Bus drive only answers a read strobe held three edges earlier
	oe_after_read_a: assert property (
		$rose(cpu_data_oe) |-> $past(cpu_cs_n, 3) == 1'b0 && $past(cpu_rd_n, 3) == 1'b0)
		else $error("Data enable rose without a read");
	// Bus released once the read strobe stays high
	oe_release_a: assert property (
		cpu_rd_n [*5] |-> !cpu_data_oe)
		else $error("Data enable held after the read ended");
	// Read data moves only with a new read answer
	data_hold_a: assert property (
		$changed(cpu_data_out) |-> $rose(cpu_data_oe))
		else $error("Read data changed outside a read");
	// Holes in the map read zero
	unmapped_zero_a: assert property (
		$rose(cpu_data_oe) && ($past(cpu_addr, 3) < 10'h114 || $past(cpu_addr, 3) > 10'h123
		|| $past(cpu_addr, 3) == 10'h117) |-> cpu_data_out == 8'h00)
		else $error("Unmapped read returned nonzero");
	// Update registers use bit 0 only
	update_bits_a: assert property (
		$rose(cpu_data_oe) && $past(cpu_addr, 3) inside {10'h120, 10'h121}
		|-> cpu_data_out[7:1] == 7'h00)
		else $error("Update register upper bits not zero");
	// Flag and enable registers use bits 3:0 only
	flag_bits_a: assert property (
		$rose(cpu_data_oe) && $past(cpu_addr, 3) inside {10'h122, 10'h123}
		|-> cpu_data_out[7:4] == 4'h0)
		else $error("Flag register upper bits not zero");
	// Interrupt rises only after a header or a write
	irq_cause_a: assert property (
		$rose(x86_mismatch_irq) |-> $past(rx_hdr.valid, 2)
		|| $past(cpu_wr_n, 3) == 1'b0 || $past(cpu_wr_n, 4) == 1'b0)
		else $error("Interrupt rose without a cause");
	// Interrupt falls only after a register access
	irq_clear_a: assert property (
		$fell(x86_mismatch_irq) |-> $past(cpu_cs_n, 3) == 1'b0 || $past(cpu_cs_n, 4) == 1'b0)
		else $error("Interrupt fell without an access");
endmodule
`default_nettype wire

/* File: tb/srpc_rx_perf_counters_test.sv */
`timescale 1ns/1ps
`default_nettype none
module srpc_rx_perf_counters_test
	import srpc_pkg::*;
();
	localparam logic [31:0] EXP_HDR = 32'hA55A03C3;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic cpu_cs_n = 1'b1, cpu_rd_n = 1'b1, cpu_wr_n = 1'b1;
	logic [9:0] cpu_addr = 10'h000;
	logic [7:0] cpu_data_in = 8'h00, cpu_data_out, rd_val;
	logic cpu_data_oe, x86_mismatch_irq;
	srpc_pkt_t rx_pkt = '0;
	srpc_hdr_t rx_hdr = '0;
	int bad_count = 0, total_checks = 0;
	always #4 mclk = ~mclk;
	srpc_rx_perf_counters dut (.mclk(mclk), .rst_n(rst_n), .cpu_cs_n(cpu_cs_n),
		.cpu_rd_n(cpu_rd_n), .cpu_wr_n(cpu_wr_n), .cpu_addr(cpu_addr),
		.cpu_data_in(cpu_data_in), .cpu_data_out(cpu_data_out), .cpu_data_oe(cpu_data_oe),
		.rx_pkt(rx_pkt), .rx_hdr(rx_hdr), .expected_sapi_high(EXP_HDR[31:24]),
		.expected_sapi_low(EXP_HDR[23:16]), .expected_control_value(EXP_HDR[15:8]),
		.expected_address_value(EXP_HDR[7:0]), .x86_mismatch_irq(x86_mismatch_irq));
	// Print counts and verdict, then stop
	task automatic close_out();
		$display("Checks %0d, mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Hold the read strobe until the device drives the bus
	task automatic rd(input logic [9:0] a);
		int n;
		n = 0;
		@(negedge mclk);
		cpu_addr = a;
		cpu_cs_n = 1'b0;
		cpu_rd_n = 1'b0;
		while (cpu_data_oe !== 1'b1) begin
			@(negedge mclk);
			n++;
			if (n > 20) begin
				bad_count++;
				$display("MISMATCH read answer at %h never came", a);
				close_out();
			end
		end
		rd_val = cpu_data_out;
		cpu_cs_n = 1'b1;
		cpu_rd_n = 1'b1;
		repeat (5) @(negedge mclk);
	endtask
	// Writes have no answer: hold past the synchroniser, then idle
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(negedge mclk);
		cpu_addr = a;
		cpu_data_in = d;
		cpu_cs_n = 1'b0;
		cpu_wr_n = 1'b0;
		repeat (5) @(negedge mclk);
		cpu_cs_n = 1'b1;
		cpu_wr_n = 1'b1;
		repeat (5) @(negedge mclk);
	endtask
	task automatic rchk(input logic [9:0] a, input logic [7:0] exp);
		rd(a);
		chk($sformatf("register %h", a), exp, rd_val);
	endtask
	// Read a wide count byte by byte, low byte first
	task automatic cnt(input logic [9:0] base, input int nb, input logic [31:0] v);
		for (int i = 0; i < nb; i++) begin
			rchk(base + 10'(i), v[8*i +: 8]);
		end
	endtask
	task automatic pkt(input logic ab, input logic sv, input logic [15:0] n);
		@(negedge mclk);
		rx_pkt = {1'b1, ab, sv, n};
		@(negedge mclk);
		rx_pkt = '0;
	endtask
	task automatic hdr(input logic [31:0] flip);
		@(negedge mclk);
		rx_hdr = {1'b1, EXP_HDR ^ flip};
		@(negedge mclk);
		rx_hdr = '0;
		repeat (2) @(negedge mclk);
	endtask
	// Snapshot, then drop the request and see done clear
	task automatic upd();
		wr(SRPC_UPDATE_REQ, 8'h01);
		rchk(SRPC_UPDATE_REQ, 8'h01);
		rchk(SRPC_UPDATE_DONE, 8'h01);
		wr(SRPC_UPDATE_REQ, 8'h00);
		rchk(SRPC_UPDATE_DONE, 8'h00);
	endtask
	initial begin
		repeat (3) @(negedge mclk);
		rst_n = 1'b1;
		// All registers and the hole at 117h read zero after reset
		for (int a = 'h114; a <= 'h123; a++) begin
			rchk(a[9:0], 8'h00);
		end
		rchk(10'h100, 8'h00);
		// Traffic with carries across bytes, sorted by kind
		pkt(1'b0, 1'b0, 16'hFFFF);
		pkt(1'b0, 1'b0, 16'hFFFF);
		pkt(1'b0, 1'b0, 16'h0003);
		pkt(1'b1, 1'b0, 16'h0050);
		pkt(1'b0, 1'b1, 16'h0100);
		pkt(1'b0, 1'b1, 16'h0007);
		rchk(SRPC_GOOD_B0, 8'h00);
		upd();
		cnt(SRPC_SIZE_VIOL_B0, 3, 32'h2);
		cnt(SRPC_GOOD_B0, 4, 32'h20001);
		cnt(SRPC_ABORT_B0, 4, 32'h157);
		// Second update shows the counters restarted; counts are read-only
		pkt(1'b0, 1'b0, 16'h0011);
		upd();
		wr(SRPC_GOOD_B0, 8'hFF);
		cnt(SRPC_SIZE_VIOL_B0, 3, 32'h0);
		cnt(SRPC_GOOD_B0, 4, 32'h11);
		cnt(SRPC_ABORT_B0, 4, 32'h0);
		// Each header field mismatch alone, with only bits 0 and 2 enabled
		wr(SRPC_X86_IRQ_EN, 8'hF5);
		rchk(SRPC_X86_IRQ_EN, 8'h05);
		hdr(32'h0);
		rchk(SRPC_X86_STATUS, 8'h00);
		for (int i = 0; i < 4; i++) begin
			hdr(32'hFF << (8 * i));
			chk("mismatch irq", {7'h0, ~i[0]}, {7'h0, x86_mismatch_irq});
			rchk(SRPC_X86_STATUS, 8'(1 << i));
			rchk(SRPC_X86_STATUS, 8'h00);
			chk("irq after read", 8'h00, {7'h0, x86_mismatch_irq});
		end
		// A new mismatch in the cycle the read clears the same flag keeps it
		hdr(32'h000000FF);
		fork
			rd(SRPC_X86_STATUS);
			begin
				repeat (3) @(negedge mclk);
				rx_hdr = {1'b1, EXP_HDR ^ 32'h000000FF};
				@(negedge mclk);
				rx_hdr = '0;
			end
		join
		chk("status in race read", 8'h01, rd_val);
		chk("irq kept by new set", 8'h01, {7'h0, x86_mismatch_irq});
		rchk(SRPC_X86_STATUS, 8'h01);
		rchk(SRPC_X86_STATUS, 8'h00);
		close_out();
	end
endmodule
bind srpc_rx_perf_counters srpc_rx_perf_counters_properties chk_i (.mclk(mclk),
	.rst_n(rst_n), .cpu_cs_n(cpu_cs_n), .cpu_rd_n(cpu_rd_n), .cpu_wr_n(cpu_wr_n),
	.cpu_addr(cpu_addr), .cpu_data_out(cpu_data_out), .cpu_data_oe(cpu_data_oe),
	.rx_hdr(rx_hdr), .x86_mismatch_irq(x86_mismatch_irq));
`default_nettype wire
